// ---- rtl/irae_regs.sv ----
`default_nettype none
// Indirect pointers and arithmetic environment special registers.
module irae_regs #(
  parameter int MOVE_DELAY = irae_pkg::PTR_MOVE_DELAY
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Decode fields and stack pointer
  input  wire logic [7:0]  dest_field,
  input  wire logic [7:0]  src1_field,
  input  wire logic [7:0]  src2_field,
  input  wire logic [31:0] stack_pointer,
  // Pointer load from operand-bearing instructions
  input  wire logic        set_pointers_instr,
  // Register bank protection, one bit per bank of 16 registers
  input  wire logic [15:0] bank_protect,
  input  wire logic        user_mode,
  // Special register access
  input  wire logic        spr_wr,
  input  wire logic        spr_rd,
  input  wire logic [7:0]  spr_num,
  input  wire logic [31:0] spr_wdata,
  // Divide and multiply events
  input  wire logic        div_by_zero,
  input  wire logic        div_overflow,
  input  wire logic        mul_overflow,
  // Resolved numbers
  output logic      [7:0]  dest_abs,
  output logic      [7:0]  src1_abs,
  output logic      [7:0]  src2_abs,
  // Read data and traps
  output logic      [31:0] spr_rdata,
  output logic             prot_trap,
  output logic             range_trap,
  // Environment controls
  output logic             fast_float_select,
  output logic      [1:0]  round_mode_field,
  output logic      [5:0]  float_trap_enable
);
  // The hold counter is four bits wide, and no delay would break the move rule.
  if (MOVE_DELAY < 1 || MOVE_DELAY > 4) begin : g_bad_move_delay
    $error("MOVE_DELAY must be 1 to 4");
  end

  typedef struct packed {
    logic [7:0]  ptr_c;
    logic [7:0]  ptr_a;
    logic [7:0]  ptr_b;
    logic [7:0]  eff_c;
    logic [7:0]  eff_a;
    logic [7:0]  eff_b;
    logic [3:0]  hold;
    logic [8:0]  fenv;
    logic [5:0]  fen;
    logic [1:0]  ienv;
    logic [7:0]  dabs;
    logic [7:0]  aabs;
    logic [7:0]  babs;
    logic [31:0] rdata;
    logic        ptrap;
    logic        rtrap;
  } irae_state_t;

  irae_state_t st;
  irae_state_t next_st;
  logic [7:0]  r_dest;
  logic [7:0]  r_src1;
  logic [7:0]  r_src2;

  irae_operand_resolve u_dest (
    .field    (dest_field),
    .pointer  (st.eff_c),
    .sp_word  (stack_pointer[8:2]),
    .abs_num  (r_dest),
    .uses_ptr ()
  );
  irae_operand_resolve u_src1 (
    .field    (src1_field),
    .pointer  (st.eff_a),
    .sp_word  (stack_pointer[8:2]),
    .abs_num  (r_src1),
    .uses_ptr ()
  );
  irae_operand_resolve u_src2 (
    .field    (src2_field),
    .pointer  (st.eff_b),
    .sp_word  (stack_pointer[8:2]),
    .abs_num  (r_src2),
    .uses_ptr ()
  );

  function automatic logic bank_hit(input logic [7:0] n,
                                    input logic [15:0] prot);
    bank_hit = prot[n[7:4]];
  endfunction : bank_hit

  always_comb begin
    logic [7:0] wptr;
    logic       violate;
    next_st = st;
    wptr    = spr_wdata[irae_pkg::PTR_MSB:irae_pkg::PTR_LSB];
    violate = 1'b0;
    next_st.ptrap = 1'b0;
    next_st.rtrap = 1'b0;
    // The delayed copy keeps a move from steering the very next access.
    if (st.hold != 4'h0) begin
      next_st.hold = st.hold - 4'h1;
    end else begin
      next_st.eff_c = st.ptr_c;
      next_st.eff_a = st.ptr_a;
      next_st.eff_b = st.ptr_b;
    end
    if (set_pointers_instr) begin
      violate = user_mode && (bank_hit(r_dest, bank_protect) ||
                bank_hit(r_src1, bank_protect) ||
                bank_hit(r_src2, bank_protect));
      if (violate) begin
        next_st.ptrap = 1'b1;
      end else begin
        next_st.ptr_c = r_dest;
        next_st.ptr_a = r_src1;
        next_st.ptr_b = r_src2;
        next_st.eff_c = r_dest;
        next_st.eff_a = r_src1;
        next_st.eff_b = r_src2;
        next_st.hold  = 4'h0;
      end
    end else if (spr_wr) begin
      if (spr_num == irae_pkg::SPR_DEST_PTR) begin
        next_st.ptr_c = wptr;
        next_st.hold  = 4'(MOVE_DELAY);
      end else if (spr_num == irae_pkg::SPR_SRC1_PTR) begin
        next_st.ptr_a = wptr;
        next_st.hold  = 4'(MOVE_DELAY);
      end else if (spr_num == irae_pkg::SPR_SRC2_PTR) begin
        next_st.ptr_b = wptr;
        next_st.hold  = 4'(MOVE_DELAY);
      end else if (spr_num >= irae_pkg::SPR_VIRT_FIRST) begin
        next_st.ptrap = 1'b1;
      end
      // Other unprotected numbers fall through unchanged.
    end
    // The environment registers are virtual, so only software emulation
    // running in the trap handler may reach them through this port.
    if (spr_wr && !set_pointers_instr && !user_mode) begin
      if (spr_num == irae_pkg::SPR_FLOAT_ENV) begin
        next_st.fenv = spr_wdata[8:0] & irae_pkg::FE_WMASK;
      end else if (spr_num == irae_pkg::SPR_INT_ENV) begin
        next_st.ienv = spr_wdata[1:0] & irae_pkg::IE_WMASK;
      end
    end
    // Enables are kept as their own flops so the outputs need no inverter.
    next_st.fen = ~next_st.fenv[5:0];
    if (spr_rd) begin
      next_st.rdata = 32'h0000_0000;
      if (spr_num == irae_pkg::SPR_DEST_PTR) begin
        next_st.rdata = {22'h0, st.ptr_c, 2'h0};
      end else if (spr_num == irae_pkg::SPR_SRC1_PTR) begin
        next_st.rdata = {22'h0, st.ptr_a, 2'h0};
      end else if (spr_num == irae_pkg::SPR_SRC2_PTR) begin
        next_st.rdata = {22'h0, st.ptr_b, 2'h0};
      end else if (spr_num >= irae_pkg::SPR_VIRT_FIRST) begin
        next_st.ptrap = 1'b1;
        if (!user_mode && spr_num == irae_pkg::SPR_FLOAT_ENV) begin
          next_st.rdata = {23'h0, st.fenv};
        end else if (!user_mode && spr_num == irae_pkg::SPR_INT_ENV) begin
          next_st.rdata = {30'h0, st.ienv};
        end
      end
    end
    next_st.rtrap = div_by_zero;
    if (div_overflow && !st.ienv[irae_pkg::IE_DIVO]) begin
      next_st.rtrap = 1'b1;
    end
    if (mul_overflow && !st.ienv[irae_pkg::IE_MULO]) begin
      next_st.rtrap = 1'b1;
    end
    next_st.dabs = r_dest;
    next_st.aabs = r_src1;
    next_st.babs = r_src2;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st       <= '0;
      st.ptr_c <= irae_pkg::PTR_RESET;
      st.ptr_a <= irae_pkg::PTR_RESET;
      st.ptr_b <= irae_pkg::PTR_RESET;
      st.fenv  <= irae_pkg::FE_RESET;
      st.fen   <= ~irae_pkg::FE_RESET[5:0];
      st.ienv  <= irae_pkg::IE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign dest_abs          = st.dabs;
  assign src1_abs          = st.aabs;
  assign src2_abs          = st.babs;
  assign spr_rdata         = st.rdata;
  assign prot_trap         = st.ptrap;
  assign range_trap        = st.rtrap;
  assign fast_float_select = st.fenv[irae_pkg::FE_FAST];
  assign round_mode_field  = st.fenv[irae_pkg::FE_RND_LSB +: 2];
  // Bit order of the enables: divzero, inexact, underflow, overflow,
  // reserved operand, invalid; an enable is high when its mask is zero.
  assign float_trap_enable[5] = st.fen[irae_pkg::FE_DIVZ];
  assign float_trap_enable[4] = st.fen[irae_pkg::FE_INEX];
  assign float_trap_enable[3] = st.fen[irae_pkg::FE_UNDF];
  assign float_trap_enable[2] = st.fen[irae_pkg::FE_OVF];
  assign float_trap_enable[1] = st.fen[irae_pkg::FE_RSVD];
  assign float_trap_enable[0] = st.fen[irae_pkg::FE_INVL];
endmodule : irae_regs
`default_nettype wire

// ---- rtl/irae_pkg.sv ----
// Notes on behaviour
// - Unimplemented special register reads are undefined; here zero.
// - Unimplemented unprotected special register writes change nothing.
// - Operand field zero takes its number from the matching pointer.
// - Three independent 8-bit pointers: result, source one, source two.
// - Pointer values are absolute numbers; no stack-pointer offset added.
// - Move-to-special-register stores source bits 9 to 2 into a pointer.
// - Pointer moves reach addressing only after a pipeline delay.
// - Set-pointer and arithmetic instructions load all three pointers.
// - Non-move pointer loads are checked against bank protection.
// - Result pointer is special register 128, sources 129 and 130.
// - Pointer sits in bits 9 to 2; bits 1-0 zero; upper bits reserved.
// - Float environment bit 8 selects fast, relaxed floating point.
// - Rounding field bits 7-6: nearest, minus inf, plus inf, toward zero.
// - Bit 5 zero lets floating divide-by-zero trap.
// - Bit 4 zero lets inexact results trap.
// - Bit 3 zero lets underflow trap; bit 2 zero lets overflow trap.
// - Bit 1 zero lets reserved operands trap.
// - Bit 0 zero lets invalid operations trap.
// - Integer bit 1 zero lets divide overflow raise out-of-range trap.
// - Integer division by zero always raises out-of-range trap.
// - Integer bit 0 zero lets multiply overflow trap; set it for 64-bit.
// - Reserved bits read as zero; writing ones to them does nothing.
// - Local: number plus stack-pointer bits 8 to 2, seven bits, top one.
// - Special numbers 160 to 255 raise a protection violation on access.
`default_nettype none
package irae_pkg;
  localparam logic [7:0] SPR_DEST_PTR   = 8'h80;
  localparam logic [7:0] SPR_SRC1_PTR   = 8'h81;
  localparam logic [7:0] SPR_SRC2_PTR   = 8'h82;
  localparam logic [7:0] SPR_FLOAT_ENV  = 8'ha0;
  localparam logic [7:0] SPR_INT_ENV    = 8'ha1;
  localparam logic [7:0] SPR_VIRT_FIRST = 8'ha0;
  localparam logic [7:0] SPR_UNPROT_LO  = 8'h80;
  localparam logic [7:0] SPR_UNPROT_HI  = 8'h9f;
  localparam int PTR_LSB = 2;
  localparam int PTR_MSB = 9;
  localparam int FE_FAST = 8;
  localparam int FE_RND_LSB = 6;
  localparam int FE_DIVZ = 5;
  localparam int FE_INEX = 4;
  localparam int FE_UNDF = 3;
  localparam int FE_OVF  = 2;
  localparam int FE_RSVD = 1;
  localparam int FE_INVL = 0;
  localparam int IE_DIVO = 1;
  localparam int IE_MULO = 0;
  localparam logic [8:0] FE_WMASK = 9'h1ff;
  localparam logic [1:0] IE_WMASK = 2'h3;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [8:0] FE_RESET  = 9'h000;
  localparam logic [1:0] IE_RESET  = 2'h0;
  localparam int PTR_MOVE_DELAY = 2;
  typedef enum logic [1:0] {
    IRAE_RND_NEAREST, IRAE_RND_MINUS, IRAE_RND_PLUS, IRAE_RND_ZERO
  } irae_round_t;
endpackage : irae_pkg
`default_nettype wire

// ---- rtl/irae_operand_resolve.sv ----
`default_nettype none
// Turns one instruction register field into an absolute register number.
module irae_operand_resolve (
  // Field and context
  input  wire logic [7:0] field,
  input  wire logic [7:0] pointer,
  input  wire logic [6:0] sp_word,
  // Result
  output logic      [7:0] abs_num,
  output logic            uses_ptr
);
  logic [6:0] local_sum;
  always_comb begin
    local_sum = field[6:0] + sp_word;
    uses_ptr  = (field == 8'h00);
    if (uses_ptr) begin
      abs_num = pointer;
    end else if (field[7]) begin
      abs_num = {1'b1, local_sum};
    end else begin
      abs_num = field;
    end
  end
endmodule : irae_operand_resolve
`default_nettype wire

// ---- sim/irae_sva.sv ----
`default_nettype none
module irae_sva (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Requests
  input wire logic        spr_wr,
  input wire logic        spr_rd,
  input wire logic        set_pointers_instr,
  input wire logic        user_mode,
  input wire logic [7:0]  spr_num,
  input wire logic [31:0] spr_wdata,
  input wire logic [7:0]  src1_field,
  input wire logic [31:0] stack_pointer,
  input wire logic        div_by_zero,
  // Answers
  input wire logic [7:0]  src1_abs,
  input wire logic [31:0] spr_rdata,
  input wire logic        prot_trap,
  input wire logic        range_trap,
  input wire logic        fast_float_select,
  input wire logic [1:0]  round_mode_field,
  input wire logic [5:0]  float_trap_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic fe_wr;
  // Only a supervisor write without a competing pointer load lands.
  assign fe_wr = spr_wr && spr_num == 8'ha0 && !user_mode
                 && !set_pointers_instr;
  a_divzero_trap: assert property (div_by_zero |=> range_trap)
    else $error("range trap missing on divide by zero");
  a_local_offset: assert property (src1_field[7] |=>
    src1_abs == {1'h1, $past(src1_field[6:0]) + $past(stack_pointer[8:2])})
    else $error("local number not offset");
  a_global_direct: assert property (src1_field != 8'h00
    && !src1_field[7] |=> src1_abs == $past(src1_field))
    else $error("global number altered");
  a_unprot_ignored: assert property (spr_wr
    && spr_num inside {[8'h83:8'h9f]} |=> $stable(float_trap_enable)
    && $stable(round_mode_field) && $stable(fast_float_select))
    else $error("unimplemented write changed state");
  a_ptr_rsvd_zero: assert property (spr_rd
    && spr_num inside {[8'h80:8'h82]}
    |=> spr_rdata[31:10] == 22'h0 && spr_rdata[1:0] == 2'h0)
    else $error("pointer reserved bits set");
  a_virt_prot: assert property ((spr_rd || spr_wr)
    && spr_num >= 8'ha0 && !set_pointers_instr |=> prot_trap)
    else $error("no protection trap on virtual access");
  a_fast_sel: assert property (fe_wr
    |=> fast_float_select == $past(spr_wdata[8]))
    else $error("fast select wrong");
  a_round_mode: assert property (fe_wr
    |=> round_mode_field == $past(spr_wdata[7:6]))
    else $error("round mode wrong");
  a_mask_map: assert property (fe_wr
    |=> float_trap_enable == ~$past(spr_wdata[5:0]))
    else $error("trap enables wrong");
  c_prot_load: cover property (set_pointers_instr && user_mode);
  c_env_write: cover property (fe_wr);
  c_range: cover property (range_trap);
endmodule : irae_sva
bind irae_regs irae_sva u_sva (.clk(clk), .sys_rst(sys_rst),
  .spr_wr(spr_wr), .spr_rd(spr_rd), .set_pointers_instr(set_pointers_instr),
  .user_mode(user_mode), .spr_num(spr_num), .spr_wdata(spr_wdata),
  .src1_field(src1_field), .stack_pointer(stack_pointer),
  .div_by_zero(div_by_zero), .src1_abs(src1_abs), .spr_rdata(spr_rdata),
  .prot_trap(prot_trap), .range_trap(range_trap),
  .fast_float_select(fast_float_select),
  .round_mode_field(round_mode_field),
  .float_trap_enable(float_trap_enable));
`default_nettype wire

// ---- sim/irae_decode_model.sv ----
`default_nettype none
module irae_decode_model (
  // Clock
  input  wire logic       clk,
  // Decode outputs
  output var logic [7:0]  dest_field = 8'h00,
  output var logic [7:0]  src1_field = 8'h00,
  output var logic [7:0]  src2_field = 8'h00,
  output var logic [31:0] stack_pointer = 32'h0,
  output var logic        set_pointers_instr = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Fields change at the falling edge so the block samples settled values.
  task automatic fields(input logic [7:0] d, a, b, input logic [31:0] sp);
    @(negedge clk);
    {dest_field, src1_field, src2_field, stack_pointer} = {d, a, b, sp};
  endtask : fields
  task automatic setp();
    @(negedge clk);
    set_pointers_instr = 1'h1;
    @(negedge clk);
    set_pointers_instr = 1'h0;
  endtask : setp
endmodule : irae_decode_model
`default_nettype wire

// ---- sim/testbench.sv ----
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0, sys_rst = 1'h1, spr_wr = 1'h0, spr_rd = 1'h0;
  logic        user_mode = 1'h0, div_by_zero = 1'h0, div_overflow = 1'h0;
  logic        mul_overflow = 1'h0, set_pointers_instr, prot_trap;
  logic        range_trap, fast_float_select;
  logic [7:0]  spr_num = 8'h00, dest_field, src1_field, src2_field;
  logic [7:0]  dest_abs, src1_abs, src2_abs;
  logic [15:0] bank_protect = 16'h0000;
  logic [31:0] spr_wdata = 32'h0, stack_pointer, spr_rdata;
  logic [1:0]  round_mode_field;
  logic [5:0]  float_trap_enable;
  int          fails = 0, compares = 0;
  always #2 clk = ~clk;
  irae_decode_model u_dec (.clk, .dest_field, .src1_field, .src2_field,
    .stack_pointer, .set_pointers_instr);
  irae_regs #(.MOVE_DELAY(2)) DUT (.clk, .sys_rst, .dest_field, .src1_field,
    .src2_field, .stack_pointer, .set_pointers_instr, .bank_protect,
    .user_mode, .spr_wr, .spr_rd, .spr_num, .spr_wdata, .div_by_zero,
    .div_overflow, .mul_overflow, .dest_abs, .src1_abs, .src2_abs, .spr_rdata,
    .prot_trap, .range_trap, .fast_float_select, .round_mode_field,
    .float_trap_enable);
  task automatic chk(input string what, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] n, input logic [31:0] d);
    @(negedge clk);
    {spr_wr, spr_rd, spr_num, spr_wdata} = {w, !w, n, d};
    @(negedge clk);
    {spr_wr, spr_rd} = 2'h0;
  endtask : acc
  task automatic ev(input logic [2:0] v, input logic exp);
    @(negedge clk);
    {div_by_zero, div_overflow, mul_overflow} = v;
    @(negedge clk);
    {div_by_zero, div_overflow, mul_overflow} = 3'h0;
    chk("range_trap", 32'(range_trap), 32'(exp));
  endtask : ev
  task automatic t_move();
    chk("enables", 32'(float_trap_enable), 32'h3f);
    acc(1'h0, 8'h80, 32'h0);
    chk("dest reset", spr_rdata, 32'h0);
    u_dec.fields(8'h00, 8'h00, 8'h00, 32'h1f8);
    acc(1'h1, 8'h81, 32'hffff_f004);
    acc(1'h1, 8'h82, 32'h0000_0208);
    acc(1'h1, 8'h80, 32'hffff_fabd);
    repeat (3) @(negedge clk);
    chk("dest old", 32'(dest_abs), 32'h0);
    @(negedge clk);
    chk("dest new", 32'(dest_abs), 32'haf);
    chk("src1", 32'(src1_abs), 32'h01);
    chk("src2", 32'(src2_abs), 32'h82);
    acc(1'h0, 8'h80, 32'h0);
    chk("dest read", spr_rdata, 32'h2bc);
  endtask : t_move
  task automatic t_setp();
    u_dec.fields(8'h05, 8'h83, 8'h10, 32'h1f8);
    u_dec.setp();
    acc(1'h0, 8'h81, 32'h0);
    chk("src1 set", spr_rdata, 32'h204);
    user_mode = 1'h1;
    bank_protect = 16'h0001;
    u_dec.fields(8'h07, 8'h11, 8'h10, 32'h1f8);
    u_dec.setp();
    chk("prot", 32'(prot_trap), 32'h1);
    acc(1'h0, 8'h80, 32'h0);
    chk("dest kept", spr_rdata, 32'h14);
    user_mode = 1'h0;
  endtask : t_setp
  task automatic t_env();
    for (int m = 0; m < 4; m++) begin
      acc(1'h1, 8'ha0, {23'h7fffff, 1'h1, 2'(m), 6'h2a});
      chk("round", 32'(round_mode_field), 32'(m));
      chk("fast", 32'(fast_float_select), 32'h1);
      chk("enables", 32'(float_trap_enable), 32'h15);
      acc(1'h0, 8'ha0, 32'h0);
      chk("env read", spr_rdata, {23'h0, 1'h1, 2'(m), 6'h2a});
    end
    acc(1'h1, 8'ha1, 32'h0);
    ev(3'h2, 1'h1);
    ev(3'h1, 1'h1);
    acc(1'h1, 8'ha1, 32'h3);
    ev(3'h2, 1'h0);
    ev(3'h1, 1'h0);
    ev(3'h4, 1'h1);
    acc(1'h1, 8'h85, 32'hffff_ffff);
    chk("unimpl", 32'(float_trap_enable), 32'h15);
    acc(1'h0, 8'hc0, 32'h0);
    chk("virt", 32'(prot_trap), 32'h1);
  endtask : t_env
  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial begin
    repeat (16) @(negedge clk);
    sys_rst = 1'h0;
    t_move();
    t_setp();
    t_env();
    final_report();
  end
  // The tests need well under a thousand cycles; this cuts a hang short.
  initial begin
    #20000;
    fails++;
    final_report();
  end
endmodule : testbench
`default_nettype wire
